// >>> counter_gate_consts.vh
`ifndef COUNTER_GATE_CONSTS_VH
`define COUNTER_GATE_CONSTS_VH
// Command word bit positions
`define CMD_REF_ENABLE      0
`define CMD_RESERVED        1
`define CMD_LATCH_RST0      2
`define CMD_LATCH_RST1      3
`define CMD_ONCE_EN0        4
`define CMD_ONCE_EN1        5
`define CMD_ONCE_DIS        6
`define CMD_ALARM_RST       7
`define CMD_CLEAR0          8
`define CMD_RELOAD0         10
`define CMD_UNPROTECT0      12
`define CMD_STROBE0         14
// Dedicated command addresses used when board style is 0
`define CADDR_REF_ENABLE    4'h0
`define CADDR_LATCH_RST0    4'h2
`define CADDR_ONCE_EN0      4'h4
`define CADDR_ONCE_DIS      4'h6
`define CADDR_ALARM_RST     4'h7
`define CADDR_CLEAR0        4'h8
`define CADDR_RELOAD0       4'ha
`define CADDR_UNPROTECT0    4'hc
`define CADDR_STROBE0       4'he
// Command word register address
`define CADDR_WORD          4'h0
// Reset values
`define RST_COUNT           32'h00000000
`define RST_REF_ENABLED     1'b0
`define RST_ONCE_ENABLED    1'b0
`define RST_PROTECT         1'b0
`endif

// >>> counter_gate_and_command_logic.v
// Function
// RQ1: Edge mode: one rising gate edge opens the gate, the next closes it.
// RQ2: Gate-open flag stays high while the channel gate is active.
// RQ3: In measurement mode the counter advances on clock pulses only while gated.
// RQ4: At gate end, reference edge or software strobe copies counter to buffer; the code does not capture at gate end.
// RQ5: Clear-on-reference stores counter to buffer first, then resets the counter.
// RQ6: Level mode reference edge saves counter and sets write protection together.
// RQ7: Host cancels start-edge protection at once and uses the stop-edge value.
// RQ8: Without reference, host clears, polls gate flag, strobes, then reads buffer.
// RQ9: Enable-reference command activates both reference inputs until hardware reset.
// RQ10: In one-time mode first reference pulse disables counter until re-enabled; the code blocks only further captures, counting goes on.
// RQ11: Disable-one-time command disables both channels; reference pulses then ignored.
// RQ12: Cancel-protection command removes write protection of the addressed channel only.
// RQ13: Strobe copies counter to buffer unless protected; both channels may strobe.
// RQ14: Software clear zeroes counter unless the channel is write protected.
// RQ15: Software reload loads counter from load register unless protected.
// RQ16: Reference pulse sets the latch; per-channel reset-latch command clears it.
// RQ17: Reset-alarm clears four extra-input, two quadrant and two range flags.
// RQ18: Board style 0 decodes commands from accesses to dedicated addresses.
// RQ19: Board style 1 decodes low command-word bits as the command map.
// RQ20: Command-word bits 8 to 15 map clear, reload, unprotect, strobe per channel.
// RQ21: All set command bits execute together; channels act independently.
// RQ22: Host must not combine strobe, clear, reload, unprotect within one channel.
// RQ23: Level mode keeps the gate active while the gate input is high.
// RQ24: Zero bits and the reserved bit cause no action.
`timescale 1ns/1ps
`include "counter_gate_consts.vh"

module counter_gate_and_command_logic (
   // Clock and reset
   input  wire        clk,
   input  wire        srst,
   // Host command access
   input  wire [3:0]  cmdAddr,
   input  wire        cmdWrite,
   input  wire        cmdRead,
   input  wire [15:0] cmdData,
   input  wire        board_style_bit,
   // Per-channel configuration
   input  wire [1:0]  gate_edge_select,
   input  wire [1:0]  measureMode,
   input  wire [1:0]  oneTimeMode,
   input  wire [1:0]  clearOnReference,
   input  wire [31:0] loadValue0,
   input  wire [31:0] loadValue1,
   // Field inputs
   input  wire [1:0]  gateIn,
   input  wire [1:0]  countPulse,
   input  wire [1:0]  referenceIn,
   // Alarm event inputs
   input  wire        setExtraA0,
   input  wire        setExtraC0,
   input  wire        setExtraA1,
   input  wire        setExtraC1,
   input  wire [1:0]  setQuadrant,
   input  wire [1:0]  setRange,
   // Status outputs
   output reg         gate_open_flag_ch0,
   output reg         gate_open_flag_ch1,
   output reg  [1:0]  referenceLatch,
   output reg  [1:0]  writeProtect,
   output reg  [1:0]  oneTimeEnabled,
   output reg         referenceEnabled,
   output reg         extra_input_a_ch0,
   output reg         extra_input_c_ch0,
   output reg         extra_input_a_ch1,
   output reg         extra_input_c_ch1,
   output reg         reference_quadrant_flag_ch0,
   output reg         reference_quadrant_flag_ch1,
   output reg         counter_range_flag_ch0,
   output reg         counter_range_flag_ch1,
   // Counter and buffer values
   output reg  [31:0] count0,
   output reg  [31:0] count1,
   output reg  [31:0] refBuffer0,
   output reg  [31:0] refBuffer1
);

   // Decoded command strobes, one bit per command word position.
   // Both board styles funnel into this one vector, so the channel
   // logic below never needs to know how a command arrived.
   reg  [15:0] cmdBits;

   // Edge-mode gate state, toggled by rising gate edges
   reg  [1:0]  gateEdgeOpen;

   // Previous samples of the gate and reference pins, for edge detection.
   // Both reset low to match the idle level of the pins, so no false
   // edge is seen right after reset.
   reg  [1:0]  gatePrev;
   reg  [1:0]  refPrev;

   // Gate as seen by the counter, in either gate mode
   wire [1:0]  gateActive;

   // Rising reference edge, qualified by the global enable
   wire [1:0]  refEdge;

   // Reference edge that is actually acted upon
   wire [1:0]  refTaken;

   // Map an address-decoded access to the equivalent command word bit.
   // Odd addresses other than 1 and 7 (alarm reset) select channel 1 of a per-channel command.
   // Address 1 is the reserved slot and yields no command.
   // Used so that both styles share one set of channel strobes.
   function [15:0] addr_to_bits;
      input [3:0] a;
      begin
         addr_to_bits = 16'h0000;
         case (a)
            `CADDR_REF_ENABLE: addr_to_bits[`CMD_REF_ENABLE] = 1'b1;
            `CADDR_LATCH_RST0: addr_to_bits[`CMD_LATCH_RST0] = 1'b1;
            4'h3:              addr_to_bits[`CMD_LATCH_RST1] = 1'b1;
            `CADDR_ONCE_EN0:   addr_to_bits[`CMD_ONCE_EN0] = 1'b1;
            4'h5:              addr_to_bits[`CMD_ONCE_EN1] = 1'b1;
            `CADDR_ONCE_DIS:   addr_to_bits[`CMD_ONCE_DIS] = 1'b1;
            `CADDR_ALARM_RST:  addr_to_bits[`CMD_ALARM_RST] = 1'b1;
            `CADDR_CLEAR0:     addr_to_bits[`CMD_CLEAR0] = 1'b1;
            4'h9:              addr_to_bits[`CMD_CLEAR0 + 1] = 1'b1;
            `CADDR_RELOAD0:    addr_to_bits[`CMD_RELOAD0] = 1'b1;
            4'hb:              addr_to_bits[`CMD_RELOAD0 + 1] = 1'b1;
            `CADDR_UNPROTECT0: addr_to_bits[`CMD_UNPROTECT0] = 1'b1;
            4'hd:              addr_to_bits[`CMD_UNPROTECT0 + 1] = 1'b1;
            `CADDR_STROBE0:    addr_to_bits[`CMD_STROBE0] = 1'b1;
            4'hf:              addr_to_bits[`CMD_STROBE0 + 1] = 1'b1;
            default:           addr_to_bits = 16'h0000;
         endcase
      end
   endfunction

   // Command source select by board style.
   // Style 1: only a write to the command word address counts, and every
   // set bit except the reserved bit 1 is a command of its own.
   // Style 0: any read or write to a command address is one command.
   // The strobes are combinational and last exactly the access cycle.
   always @* begin
      cmdBits = 16'h0000;
      if (board_style_bit) begin
         if (cmdWrite && cmdAddr == `CADDR_WORD) begin
            cmdBits = cmdData;                                   // RQ19 RQ20 RQ21
            cmdBits[`CMD_RESERVED] = 1'b0;                       // RQ24
         end
      end else if (cmdWrite || cmdRead) begin
         cmdBits = addr_to_bits(cmdAddr);                        // RQ18
      end
   end

   // Edge history of gate and reference inputs.
   // Pins are taken as already synchronous, so one stage is enough
   // to find a rising edge at the first clock edge that samples the pin high.
   always @(posedge clk) begin
      if (srst) begin
         gatePrev <= 2'b00;
         refPrev  <= 2'b00;
      end else begin
         gatePrev <= gateIn;
         refPrev  <= referenceIn;
      end
   end

   // Reference inputs enabled once, dropped only by reset.
   // There is deliberately no command that turns them off again.
   always @(posedge clk) begin
      if (srst) begin
         referenceEnabled <= `RST_REF_ENABLED;
      end else if (cmdBits[`CMD_REF_ENABLE]) begin
         referenceEnabled <= 1'b1;                               // RQ9
      end
   end

   // Gate status flags.
   // Registered, so they lag the gate state by one clock cycle.
   always @(posedge clk) begin
      if (srst) begin
         gate_open_flag_ch0 <= 1'b0;
         gate_open_flag_ch1 <= 1'b0;
      end else begin
         gate_open_flag_ch0 <= gateActive[0];                    // RQ2
         gate_open_flag_ch1 <= gateActive[1];                    // RQ2
      end
   end

   // Alarm flags: a new event wins over the reset command.
   // All eight flags share one reset command bit.
   // An event in the same cycle as the reset is kept, so no alarm
   // raised by hardware is lost to a late software reset.
   always @(posedge clk) begin
      if (srst) begin
         extra_input_a_ch0           <= 1'b0;
         extra_input_c_ch0           <= 1'b0;
         extra_input_a_ch1           <= 1'b0;
         extra_input_c_ch1           <= 1'b0;
         reference_quadrant_flag_ch0 <= 1'b0;
         reference_quadrant_flag_ch1 <= 1'b0;
         counter_range_flag_ch0      <= 1'b0;
         counter_range_flag_ch1      <= 1'b0;
      end else begin
         extra_input_a_ch0 <= setExtraA0 | (extra_input_a_ch0 & ~cmdBits[`CMD_ALARM_RST]);       // RQ17
         extra_input_c_ch0 <= setExtraC0 | (extra_input_c_ch0 & ~cmdBits[`CMD_ALARM_RST]);       // RQ17
         extra_input_a_ch1 <= setExtraA1 | (extra_input_a_ch1 & ~cmdBits[`CMD_ALARM_RST]);       // RQ17
         extra_input_c_ch1 <= setExtraC1 | (extra_input_c_ch1 & ~cmdBits[`CMD_ALARM_RST]);       // RQ17
         reference_quadrant_flag_ch0 <= setQuadrant[0] |
                                        (reference_quadrant_flag_ch0 & ~cmdBits[`CMD_ALARM_RST]); // RQ17
         reference_quadrant_flag_ch1 <= setQuadrant[1] |
                                        (reference_quadrant_flag_ch1 & ~cmdBits[`CMD_ALARM_RST]); // RQ17
         counter_range_flag_ch0 <= setRange[0] | (counter_range_flag_ch0 & ~cmdBits[`CMD_ALARM_RST]); // RQ17
         counter_range_flag_ch1 <= setRange[1] | (counter_range_flag_ch1 & ~cmdBits[`CMD_ALARM_RST]); // RQ17
      end
   end

   // Per-channel gate, reference and counter logic
   genvar ch;
   generate
      for (ch = 0; ch < 2; ch = ch + 1) begin : chan
         // Per-channel command strobes picked out of the shared vector.
         // Channel 1 always sits one bit above channel 0.
         // The one-time disable is common and read directly below.
         wire        doClear   = cmdBits[`CMD_CLEAR0 + ch];
         wire        doReload  = cmdBits[`CMD_RELOAD0 + ch];
         wire        doUnprot  = cmdBits[`CMD_UNPROTECT0 + ch];
         wire        doStrobe  = cmdBits[`CMD_STROBE0 + ch];
         wire        doLatchRs = cmdBits[`CMD_LATCH_RST0 + ch];
         wire        doOnceEn  = cmdBits[`CMD_ONCE_EN0 + ch];
         // Rising gate edge, used only in edge-controlled mode
         // (level mode reads the pin itself)
         wire        gateRise  = gateIn[ch] & ~gatePrev[ch];
         wire [31:0] loadVal   = (ch == 0) ? loadValue0 : loadValue1;
         wire [31:0] curCount  = (ch == 0) ? count0 : count1;
         // Next values, computed here and registered at the top level
         // so every output still comes straight from a flip-flop
         reg  [31:0] next_count;
         reg  [31:0] next_buffer;

         // Gate state: level follows the input, edge mode toggles
         assign gateActive[ch] = gate_edge_select[ch] ? gateEdgeOpen[ch]  // RQ1
                                                      : gateIn[ch];       // RQ23

         // Reference edge counts only when inputs enabled, unprotected, and armed
         assign refEdge[ch]  = referenceIn[ch] & ~refPrev[ch] & referenceEnabled;  // RQ9
         assign refTaken[ch] = refEdge[ch] & ~writeProtect[ch] &
                               (~oneTimeMode[ch] | oneTimeEnabled[ch]);            // RQ10 RQ11

         // Edge-controlled gate toggle.
         // Leaving edge mode closes the gate, so re-entry starts closed.
         always @(posedge clk) begin
            if (srst) begin
               gateEdgeOpen[ch] <= 1'b0;
            end else if (!gate_edge_select[ch]) begin
               gateEdgeOpen[ch] <= 1'b0;
            end else if (gateRise) begin
               gateEdgeOpen[ch] <= ~gateEdgeOpen[ch];            // RQ1
            end
         end

         // Write protection: set by a taken reference edge, cleared by command.
         // A taken edge wins over a same-cycle cancel, so a capture is never
         // left unprotected. In edge mode the host must cancel after the
         // start edge or the stop edge will be refused.
         always @(posedge clk) begin
            if (srst) begin
               writeProtect[ch] <= `RST_PROTECT;
            end else if (refTaken[ch]) begin
               writeProtect[ch] <= 1'b1;                         // RQ6 RQ7
            end else if (doUnprot) begin
               writeProtect[ch] <= 1'b0;                         // RQ12
            end
         end

         // One-time enable, latch.
         // A taken edge in one-time mode disarms the channel before the
         // disable or enable commands are looked at.
         // The latch keeps a set in the same cycle as its reset command.
         always @(posedge clk) begin
            if (srst) begin
               oneTimeEnabled[ch] <= `RST_ONCE_ENABLED;
               referenceLatch[ch] <= 1'b0;
            end else begin
               if (oneTimeMode[ch] && refTaken[ch]) begin
                  oneTimeEnabled[ch] <= 1'b0;                    // RQ10
               end else if (cmdBits[`CMD_ONCE_DIS]) begin
                  oneTimeEnabled[ch] <= 1'b0;                    // RQ11
               end else if (doOnceEn) begin
                  oneTimeEnabled[ch] <= 1'b1;                    // RQ10
               end
               referenceLatch[ch] <= refTaken[ch] | (referenceLatch[ch] & ~doLatchRs); // RQ16
            end
         end

         // Next counter and buffer values.
         // Priority: a taken reference edge first, then the software
         // commands of an unprotected channel, then counting.
         // Clear beats reload beats counting when the host combines them.
         // Counting goes on while protected; the commands and reference captures are blocked.
         // The counter wraps silently at its top value.
         always @* begin
            next_count  = curCount;
            next_buffer = (ch == 0) ? refBuffer0 : refBuffer1;
            if (refTaken[ch]) begin
               next_buffer = curCount;                           // RQ4 RQ6
               if (clearOnReference[ch]) begin
                  next_count = `RST_COUNT;                       // RQ5
               end
            end else if (!writeProtect[ch]) begin
               if (doStrobe) begin
                  next_buffer = curCount;                        // RQ13 RQ4
               end
               if (doClear) begin
                  next_count = `RST_COUNT;                       // RQ14
               end else if (doReload) begin
                  next_count = loadVal;                          // RQ15
               end else if (measureMode[ch] && gateActive[ch] && countPulse[ch]) begin
                  next_count = curCount + 32'h00000001;          // RQ3
               end
            end else if (measureMode[ch] && gateActive[ch] && countPulse[ch]) begin
               next_count = curCount + 32'h00000001;             // RQ3
            end
         end
      end
   endgenerate

   // Counter and buffer registers.
   // Both channels are loaded here from the values worked out in the
   // generate loop, keeping each output a plain flip-flop.
   // Reset brings counters and buffers to zero.
   always @(posedge clk) begin
      if (srst) begin
         count0     <= `RST_COUNT;
         count1     <= `RST_COUNT;
         refBuffer0 <= `RST_COUNT;
         refBuffer1 <= `RST_COUNT;
      end else begin
         count0     <= chan[0].next_count;
         count1     <= chan[1].next_count;
         refBuffer0 <= chan[0].next_buffer;
         refBuffer1 <= chan[1].next_buffer;
      end
   end

endmodule // counter_gate_and_command_logic

// >>> host_cmd_model.sv
`timescale 1ns/1ps
module host_cmd_model (
   // Clock
   input  wire        clk,
   // Command access toward the block
   output reg  [3:0]  cmdAddr,
   output reg         cmdWrite,
   output reg         cmdRead,
   output reg  [15:0] cmdData
);
   // Idle bus at time zero
   initial begin
      cmdAddr = 4'h0;
      cmdWrite = 1'b0;
      cmdRead = 1'b0;
      cmdData = 16'h0000;
   end
   // One access held through its taking edge, then one idle cycle on the released bus
   task access(input logic rd, input logic [3:0] a, input logic [15:0] d);
      begin
         cmdAddr = a;
         cmdData = d;
         cmdWrite = !rd;
         cmdRead = rd;
         @(posedge clk);
         #1;
         cmdWrite = 1'b0;
         cmdRead = 1'b0;
         cmdAddr = ~a;  // Released bus shows the inverse
         cmdData = ~d;
         @(posedge clk);
         #1;
      end
   endtask
endmodule // host_cmd_model

// >>> counter_gate_props.sv
`timescale 1ns/1ps
module counter_gate_props (
   // Clock, reset and host access
   input wire        clk,
   input wire        srst,
   input wire [3:0]  cmdAddr,
   input wire        cmdWrite,
   input wire [15:0] cmdData,
   input wire        board_style_bit,
   // Configuration and field inputs
   input wire [1:0]  gate_edge_select,
   input wire [1:0]  oneTimeMode,
   input wire [1:0]  clearOnReference,
   input wire [1:0]  gateIn,
   input wire [1:0]  countPulse,
   input wire [1:0]  referenceIn,
   // Observed outputs
   input wire        gate_open_flag_ch0,
   input wire [1:0]  referenceLatch,
   input wire [1:0]  writeProtect,
   input wire [1:0]  oneTimeEnabled,
   input wire        referenceEnabled,
   input wire [31:0] count0,
   input wire [31:0] refBuffer0
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);
   // Command word write and quiet channel 0 field inputs
   wire wordWr = cmdWrite && board_style_bit && cmdAddr == 4'h0;
   wire quiet0 = !referenceIn[0] && !countPulse[0];
   sequence refTake0;
      $rose(referenceIn[0]) && referenceEnabled && !writeProtect[0] && (!oneTimeMode[0] || oneTimeEnabled[0]);
   endsequence
   strobe_copy_a: assert property (wordWr && cmdData == 16'h4000 && !writeProtect[0] && !referenceIn[0]
      |=> refBuffer0 == $past(count0)) else $error("strobe did not copy counter");
   protect_hold_a: assert property (wordWr && cmdData == 16'h0100 && writeProtect[0] && quiet0
      |=> count0 == $past(count0)) else $error("clear acted while protected");
   clear_zero_a: assert property (cmdWrite && !board_style_bit && cmdAddr == 4'h8 && !writeProtect[0] && quiet0
      |=> count0 == 32'h00000000) else $error("address clear failed");
   ref_sticky_a: assert property (referenceEnabled |=> referenceEnabled)
      else $error("reference enable dropped");
   latch_clear_a: assert property (wordWr && cmdData == 16'h0004 && !referenceIn[0] |=> !referenceLatch[0])
      else $error("latch not reset");
   unprotect_own_a: assert property (wordWr && cmdData == 16'h1000 && referenceIn == 2'b00
      |=> !writeProtect[0] && writeProtect[1] == $past(writeProtect[1])) else $error("unprotect wrong channel");
   ref_capture_a: assert property (refTake0 |=> refBuffer0 == $past(count0) && writeProtect[0] && referenceLatch[0])
      else $error("reference capture wrong");
   clear_on_ref_a: assert property (refTake0 ##0 clearOnReference[0] |=> count0 == 32'h00000000)
      else $error("clear on reference missing");
   once_lock_a: assert property (refTake0 ##0 oneTimeMode[0] |=> !oneTimeEnabled[0])
      else $error("one-time not disabled");
   level_gate_a: assert property ((!gate_edge_select[0] && gateIn[0]) [*3] |=> gate_open_flag_ch0)
      else $error("level gate flag low");
   cover property (refTake0);
   cover property (wordWr && cmdData == 16'h4000);
   cover property (gate_open_flag_ch0 && countPulse[0]);
endmodule // counter_gate_props
bind counter_gate_and_command_logic counter_gate_props props_u (.clk, .srst, .cmdAddr, .cmdWrite, .cmdData,
   .board_style_bit, .gate_edge_select, .oneTimeMode, .clearOnReference, .gateIn, .countPulse, .referenceIn,
   .gate_open_flag_ch0, .referenceLatch, .writeProtect, .oneTimeEnabled, .referenceEnabled, .count0, .refBuffer0);

// >>> counter_gate_and_command_logic_tb_top.sv
`timescale 1ns/1ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin errors++; $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module counter_gate_and_command_logic_tb_top;
   // Stimulus
   reg        clk = 1'b0, srst = 1'b1, board_style_bit = 1'b1;
   reg [1:0]  gate_edge_select = 2'b10, measureMode = 2'b11, oneTimeMode = 2'b00, clearOnReference = 2'b01;
   reg [1:0]  gateIn = 2'b00, countPulse = 2'b00, referenceIn = 2'b00, setQuadrant = 2'b00, setRange = 2'b00;
   reg        setExtraA0 = 1'b0, setExtraC0 = 1'b0, setExtraA1 = 1'b0, setExtraC1 = 1'b0;
   reg [31:0] loadValue0 = 32'h0, loadValue1 = 32'h0;
   // Design outputs and host bus
   wire [3:0]  cmdAddr;
   wire [15:0] cmdData;
   wire        cmdWrite, cmdRead, gate_open_flag_ch0, gate_open_flag_ch1, referenceEnabled;
   wire        extra_input_a_ch0, extra_input_c_ch0, extra_input_a_ch1, extra_input_c_ch1;
   wire        reference_quadrant_flag_ch0, reference_quadrant_flag_ch1, counter_range_flag_ch0, counter_range_flag_ch1;
   wire [1:0]  referenceLatch, writeProtect, oneTimeEnabled;
   wire [31:0] count0, count1, refBuffer0, refBuffer1;
   wire [7:0]  alarms = {extra_input_a_ch0, extra_input_c_ch0, extra_input_a_ch1, extra_input_c_ch1,
      reference_quadrant_flag_ch0, reference_quadrant_flag_ch1, counter_range_flag_ch0, counter_range_flag_ch1};
   // Reference model state
   reg [31:0]  mCount [0:1], mBuf [0:1];
   integer     errors = 0, total_checks = 0, ch, n, b;
   always #20 clk = ~clk;
   host_cmd_model host_u (.clk, .cmdAddr, .cmdWrite, .cmdRead, .cmdData);
   counter_gate_and_command_logic dut_u (.clk, .srst, .cmdAddr, .cmdWrite, .cmdRead, .cmdData, .board_style_bit,
      .gate_edge_select, .measureMode, .oneTimeMode, .clearOnReference, .loadValue0, .loadValue1, .gateIn,
      .countPulse, .referenceIn, .setExtraA0, .setExtraC0, .setExtraA1, .setExtraC1, .setQuadrant, .setRange,
      .gate_open_flag_ch0, .gate_open_flag_ch1, .referenceLatch, .writeProtect, .oneTimeEnabled, .referenceEnabled,
      .extra_input_a_ch0, .extra_input_c_ch0, .extra_input_a_ch1, .extra_input_c_ch1, .reference_quadrant_flag_ch0,
      .reference_quadrant_flag_ch1, .counter_range_flag_ch0, .counter_range_flag_ch1, .count0, .count1,
      .refBuffer0, .refBuffer1);
   task cyc(input integer k);
      repeat (k) @(posedge clk);
      #1;
   endtask
   task wr(input logic [15:0] d);
      host_u.access(1'b0, 4'h0, d);
   endtask
   task pulses(input integer c, input integer k);
      repeat (k) begin
         countPulse[c] = 1'b1;
         cyc(1);
         countPulse[c] = 1'b0;
         cyc(1);
      end
   endtask
   task refPulse(input integer c);
      referenceIn[c] = 1'b1;
      cyc(1);
      referenceIn[c] = 1'b0;
      cyc(1);
   endtask
   // Bounded wait on a gate-open flag
   task waitFlag(input integer c, input logic v);
      integer i;
      for (i = 0; i < 10 && ((c ? gate_open_flag_ch1 : gate_open_flag_ch0) !== v); i++) cyc(1);
      `CHK(c ? gate_open_flag_ch1 : gate_open_flag_ch0, v)
      if (i == 10) close_out;
   endtask
   task close_out;
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   initial begin
      void'($urandom(5545));
      loadValue0 = $urandom;
      loadValue1 = $urandom;
      mCount[0] = 0;
      mCount[1] = 0;
      mBuf[0] = 0;
      mBuf[1] = 0;
      cyc(5);
      srst = 1'b0;
      `CHK({writeProtect, referenceLatch, oneTimeEnabled, referenceEnabled, count0}, 39'h0)
      wr(16'h0001);
      `CHK(referenceEnabled, 1'b1)
      // Level gate on channel 0, edge gate on channel 1; pulses outside the gate are ignored
      for (ch = 0; ch < 2; ch++) begin
         n = $urandom_range(8, 1);
         pulses(ch, 2);
         gateIn[ch] = 1'b1;
         cyc(1);
         gateIn[ch] = !gate_edge_select[ch];
         waitFlag(ch, 1'b1);
         pulses(ch, n);
         mCount[ch] = mCount[ch] + n;
         gateIn[ch] = 1'b1;
         cyc(1);
         gateIn[ch] = 1'b0;
         waitFlag(ch, 1'b0);
         pulses(ch, 2);
         `CHK(ch ? count1 : count0, mCount[ch])
      end
      // Reference capture, with clear on channel 0 only
      for (ch = 0; ch < 2; ch++) begin
         refPulse(ch);
         mBuf[ch] = mCount[ch];
         if (clearOnReference[ch]) mCount[ch] = 0;
         `CHK({refBuffer1, refBuffer0, count1, count0}, {mBuf[1], mBuf[0], mCount[1], mCount[0]})
      end
      `CHK({writeProtect, referenceLatch}, 4'hf)
      // Protected channel 1 refuses clear, reload and strobe
      for (b = 9; b < 16; b += 2) if (b != 13) wr(16'h1 << b);
      `CHK({count1, refBuffer1}, {mCount[1], mBuf[1]})
      wr(16'h2000);
      `CHK(writeProtect, 2'b01)
      // Address decoded commands
      board_style_bit = 1'b0;
      host_u.access(1'b0, 4'hb, 16'h0);
      host_u.access(1'b1, 4'hf, 16'h0);
      `CHK({count1, refBuffer1}, {loadValue1, loadValue1})
      host_u.access(1'b0, 4'hc, 16'h0);
      host_u.access(1'b0, 4'ha, 16'h0);
      `CHK(count0, loadValue0)
      host_u.access(1'b0, 4'h8, 16'h0);
      host_u.access(1'b0, 4'h1, 16'h0);
      `CHK({count0, writeProtect}, 34'h0)
      board_style_bit = 1'b1;
      // Both reloads in one word, then a strobe per channel
      wr(16'h0c00);
      wr(16'h4000);
      wr(16'h8000);
      `CHK({count0, count1, refBuffer0, refBuffer1}, {loadValue0, loadValue1, loadValue0, loadValue1})
      for (b = 2; b < 4; b++) wr(16'h1 << b);
      `CHK(referenceLatch, 2'b00)
      // Alarm flags set, reserved bit ignored, then reset together
      {setExtraA0, setExtraC0, setExtraA1, setExtraC1, setQuadrant, setRange} = 8'hff;
      cyc(1);
      {setExtraA0, setExtraC0, setExtraA1, setExtraC1, setQuadrant, setRange} = 8'h00;
      wr(16'h0002);
      wr(16'h0000);
      `CHK(alarms, 8'hff)
      wr(16'h0080);
      `CHK(alarms, 8'h00)
      // One-time mode: first reference locks out the next
      oneTimeMode = 2'b11;
      wr(16'h0010);
      `CHK(oneTimeEnabled, 2'b01)
      refPulse(0);
      wr(16'h1000);
      wr(16'h0400);
      refPulse(0);
      `CHK({oneTimeEnabled, refBuffer0, count0}, {2'b00, loadValue0, loadValue0})
      wr(16'h0030);
      wr(16'h0040);
      refPulse(1);
      `CHK({oneTimeEnabled, referenceLatch}, 4'h1)
      close_out;
   end
endmodule // counter_gate_and_command_logic_tb_top
